/* sbs_ctrl.sv */
// synchronous control port of a flow-through burst static ram
//
// The register offsets and strobed register access were chosen for this implementation.
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_ctrl #(
    parameter int ADDR_W    = `SBS_ADDR_W,
    parameter int MEM_DEPTH = `SBS_MEM_DEPTH
) (
    input  wire logic                   i_core_clk,
    input  wire logic                   i_arst_n,
    input  wire logic [ADDR_W-1:0]      i_addr,
    input  wire logic                   i_proc_addr_strobe_n,
    input  wire logic                   i_ctrl_addr_strobe_n,
    input  wire logic                   i_burst_advance_n,
    input  wire logic                   i_byte_write_enable_n,
    input  wire logic [`SBS_LANES-1:0]  i_byte_sel_n,
    input  wire logic                   i_global_write_n,
    input  wire logic                   i_chip_sel_primary_n,
    input  wire logic                   i_chip_sel_second,
    input  wire logic                   i_chip_sel_third_n,
    input  wire logic                   i_out_enable_n,
    input  wire logic                   i_burst_order,
    input  wire logic                   i_sleep_req,
    input  wire logic [`SBS_DATA_W-1:0] i_data,
    output logic      [`SBS_DATA_W-1:0] o_data,
    output logic                        o_data_oe,
    output logic                        o_sleeping,
    output logic                        o_wbuf_full
);
    localparam int MAW = $clog2(MEM_DEPTH);
    localparam int LW  = `SBS_LANE_W;

    // pins come from another domain: two flops before use
    logic [ADDR_W-1:0]      addr_s1_q, addr_s2_q;
    logic [`SBS_DATA_W-1:0] data_s1_q, data_s2_q;
    logic [10:0]            ctl_s1_q, ctl_s2_q;
    logic [`SBS_LANES-1:0]  bsel_s1_q, bsel_s2_q;

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
            ctl_s1_q  <= 11'h7FF;
            ctl_s2_q  <= 11'h7FF;
            bsel_s1_q <= '1;
            bsel_s2_q <= '1;
        end
        else
        begin
            addr_s1_q <= i_addr;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= i_data;
            data_s2_q <= data_s1_q;
            ctl_s1_q  <= {i_proc_addr_strobe_n, i_ctrl_addr_strobe_n,
                          i_burst_advance_n, i_byte_write_enable_n,
                          i_global_write_n, i_chip_sel_primary_n,
                          ~i_chip_sel_second, i_chip_sel_third_n,
                          i_out_enable_n, i_burst_order, ~i_sleep_req};
            ctl_s2_q  <= ctl_s1_q;
            bsel_s1_q <= i_byte_sel_n;
            bsel_s2_q <= bsel_s1_q;
        end
    end

    logic ps_n, cs_n, adv_n, bwe_n, gw_n, ce1_n, ce2_n, ce3_n;
    logic oe_n, order, sleep;
    assign ps_n  = ctl_s2_q[10];
    assign cs_n  = ctl_s2_q[9];
    assign adv_n = ctl_s2_q[8];
    assign bwe_n = ctl_s2_q[7];
    assign gw_n  = ctl_s2_q[6];
    assign ce1_n = ctl_s2_q[5];
    assign ce2_n = ctl_s2_q[4];
    assign ce3_n = ctl_s2_q[3];
    assign oe_n  = ctl_s2_q[2];
    assign order = ctl_s2_q[1];
    assign sleep = ~ctl_s2_q[0];

    logic chip_on, p_take, c_take, load, wr_req, deselect;
    logic [`SBS_LANES-1:0] lanes;
    assign chip_on  = !ce1_n && !ce2_n && !ce3_n;
    assign p_take   = !ps_n && !ce1_n;
    assign c_take   = ps_n && !cs_n;
    assign load     = !sleep && chip_on && (p_take || c_take);
    assign deselect = !sleep && (p_take || c_take) && !chip_on;
    // processor cycle writes come one clock later; kept simple here
    always_comb
    begin
        if (!gw_n)
            lanes = '1;
        else if (!bwe_n)
            lanes = ~bsel_s2_q;
        else
            lanes = '0;
    end
    assign wr_req = (|lanes) && !p_take;

    sbs_pkg::sbs_state_type state_q;
    logic [ADDR_W-1:0]      base_q;
    logic [`SBS_CNT_W-1:0]  start_q, step_q;
    logic [`SBS_CNT_W-1:0]  offs;

    assign offs = order ? (start_q ^ step_q) : (start_q + step_q);

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            base_q  <= '0;
            start_q <= '0;
            step_q  <= '0;
        end
        else if (load)
        begin
            base_q  <= addr_s2_q;
            start_q <= addr_s2_q[`SBS_CNT_W-1:0];
            step_q  <= '0;
        end
        else if (!sleep && !adv_n && state_q != sbs_pkg::SBS_DESEL)
            step_q <= step_q + 1'b1;
    end

    logic first_rd_q;
    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            state_q    <= sbs_pkg::SBS_DESEL;
            first_rd_q <= 1'b0;
        end
        else
        begin
            first_rd_q <= 1'b0;
            if (sleep)
                state_q <= sbs_pkg::SBS_SLEEP;
            else if (deselect)
                state_q <= sbs_pkg::SBS_DESEL;
            else if (load)
            begin
                first_rd_q <= (state_q != sbs_pkg::SBS_READ) &&
                              (state_q != sbs_pkg::SBS_WRITE);
                state_q    <= sbs_pkg::SBS_READ;
            end
            else if (state_q == sbs_pkg::SBS_SLEEP)
                state_q <= sbs_pkg::SBS_DESEL;
            else if (wr_req && state_q != sbs_pkg::SBS_DESEL)
                state_q <= sbs_pkg::SBS_WRITE;
        end
    end

    // writes pass a buffer so a burst of them never stalls the array
    sbs_pkg::sbs_wr_type wr_in, wr_out;
    logic wb_valid, wb_ready, wb_push;
    // a strobed write lands at the address captured with it
    assign wr_in.addr  = load ? addr_s2_q
                       : {base_q[ADDR_W-1:`SBS_CNT_W], offs};
    assign wr_in.data  = data_s2_q;
    assign wr_in.lanes = lanes;
    assign wb_push     = wr_req && !sleep && !deselect &&
                         (load ||
                          state_q == sbs_pkg::SBS_READ ||
                          state_q == sbs_pkg::SBS_WRITE);

    sbs_fifo #(
        .WIDTH ($bits(sbs_pkg::sbs_wr_type)),
        .DEPTH (`SBS_FIFO_DEPTH)
    ) u_wbuf (
        .i_core_clk  (i_core_clk),
        .i_arst_n    (i_arst_n),
        .i_in_valid  (wb_push),
        .o_in_ready  (wb_ready),
        .i_in_data   (wr_in),
        .o_out_valid (wb_valid),
        .i_out_ready (!sleep),
        .o_out_data  (wr_out)
    );
    assign o_wbuf_full = !wb_ready;

    // array contents survive sleep: only writes are held off
    logic [`SBS_DATA_W-1:0] mem_q [MEM_DEPTH];
    logic [MAW-1:0]         wr_idx, rd_idx;
    assign wr_idx = wr_out.addr[MAW-1:0];
    assign rd_idx = wr_in.addr[MAW-1:0];

    for (genvar g = 0; g < `SBS_LANES; g++)
    begin : g_lane
        always_ff @(posedge i_core_clk)
        begin
            if (wb_valid && !sleep && wr_out.lanes[g])
                mem_q[wr_idx][g*LW +: LW] <= wr_out.data[g*LW +: LW];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_data <= '0;
        else
            o_data <= mem_q[rd_idx];
    end

    assign o_data_oe = !oe_n && !first_rd_q && !sleep &&
                       state_q == sbs_pkg::SBS_READ;
    assign o_sleeping = (state_q == sbs_pkg::SBS_SLEEP);
endmodule : sbs_ctrl

/* sbs_consts.svh */
// constants for the burst sram control port
`ifndef SBS_CONSTS_SVH
`define SBS_CONSTS_SVH
`define SBS_ADDR_W      19
`define SBS_DATA_W      36
`define SBS_LANES       4
`define SBS_LANE_W      9
`define SBS_CNT_W       2
`define SBS_FIFO_DEPTH  16
`define SBS_MEM_DEPTH   64
`endif

/* sbs_pkg.sv */
// types for the burst sram control port
`include "sbs_consts.svh"
package sbs_pkg;
    typedef enum logic [3:0] {
        SBS_DESEL = 4'h1,
        SBS_READ  = 4'h2,
        SBS_WRITE = 4'h4,
        SBS_SLEEP = 4'h8
    } sbs_state_type;

    typedef struct packed {
        logic [`SBS_ADDR_W-1:0] addr;
        logic [`SBS_DATA_W-1:0] data;
        logic [`SBS_LANES-1:0]  lanes;
    } sbs_wr_type;
endpackage : sbs_pkg

/* sbs_fifo.sv */
// small flip-flop fifo used as write buffer
`timescale 1ns/1ps
module sbs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rd_q];

    always_ff @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wr_q <= wr_q + 1'b1;
            if (pop)
                rd_q <= rd_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (push)
            mem_q[wr_q] <= i_in_data;
    end
endmodule : sbs_fifo

/* sbs_ctrl_chk.sv */
// pin-level assertions for the burst sram control port
`timescale 1ns/1ps
`include "sbs_consts.svh"
module sbs_ctrl_chk (
    input wire logic                   i_core_clk,
    input wire logic                   i_arst_n,
    input wire logic                   i_proc_addr_strobe_n,
    input wire logic                   i_ctrl_addr_strobe_n,
    input wire logic                   i_burst_advance_n,
    input wire logic                   i_byte_write_enable_n,
    input wire logic                   i_global_write_n,
    input wire logic                   i_chip_sel_primary_n,
    input wire logic                   i_out_enable_n,
    input wire logic                   i_sleep_req,
    input wire logic [`SBS_DATA_W-1:0] o_data,
    input wire logic                   o_data_oe,
    input wire logic                   o_sleeping
);
    // no controller strobe, no advance, no write: with the processor strobe also high the addressed word cannot move
    wire quiet = i_ctrl_addr_strobe_n && i_burst_advance_n
        && i_global_write_n && i_byte_write_enable_n;
    wire rd = !i_proc_addr_strobe_n && !i_chip_sel_primary_n
        && quiet && !i_sleep_req;
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    a_oe_pin:
        assert property (o_data_oe |-> !$past(i_out_enable_n, 2))
        else $error("data driven with output enable high");
    a_read_drive:
        assert property (rd && !o_sleeping ##1 (quiet && i_proc_addr_strobe_n
        && !i_out_enable_n && !i_sleep_req)[*5] |-> o_data_oe)
        else $error("read data not driven");
    a_desel_mask:
        assert property ((i_chip_sel_primary_n && !i_ctrl_addr_strobe_n)
        ##1 (i_chip_sel_primary_n && i_ctrl_addr_strobe_n)[*4] |-> !o_data_oe)
        else $error("driving while deselected");
    a_desel_hold:
        assert property ((i_chip_sel_primary_n && quiet)[*8] |-> $stable(o_data))
        else $error("data moved while deselected");
    a_idle_hold:
        assert property ((quiet && i_proc_addr_strobe_n)[*8] |-> $stable(o_data))
        else $error("data moved without a new address");
    a_sleep_enter:
        assert property (i_sleep_req[*4] |-> o_sleeping)
        else $error("sleep not entered");
    a_sleep_leave:
        assert property (!i_sleep_req[*4] |-> !o_sleeping)
        else $error("sleep not left");
    a_reset_clear:
        assert property ($rose(i_arst_n) |-> o_data == 36'h0 && !o_data_oe
        && !o_sleeping)
        else $error("outputs not clear after reset");
    c_read: cover property (rd ##4 o_data_oe);
    c_sleep: cover property ($rose(o_sleeping));
    c_burst: cover property (!i_burst_advance_n ##4 o_data_oe);
endmodule : sbs_ctrl_chk

/* sbs_host_model.sv */
// bus-side model of the processor or cache controller
`timescale 1ns/1ps
module sbs_host_model (
    input  wire logic        i_core_clk,
    output logic      [8:0]  o_ctl,
    output logic      [18:0] o_addr,
    output logic      [35:0] o_data
);
    // o_ctl: proc strobe, ctrl strobe, advance, global, byte en, lanes
    initial
    begin
        o_ctl = 9'h1FF;
        o_addr = 19'h0;
        o_data = 36'h0;
    end
    // one request, then an idle cycle so calls never collide
    task automatic cyc(input logic [8:0] k, input logic [18:0] a,
                       input logic [35:0] dv);
        o_ctl <= k;
        o_addr <= a;
        o_data <= dv;
        @(posedge i_core_clk);
        o_ctl <= 9'h1FF;
        o_addr <= ~a;
        o_data <= ~dv; // released bus never shows stale data
        @(posedge i_core_clk);
    endtask : cyc
endmodule : sbs_host_model

/* sbs_ctrl_bench.sv */
// self-checking bench for the burst sram control port
`timescale 1ns/1ps
module sbs_ctrl_bench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        ce1_n = 1'b0;
    logic        oe_n = 1'b0;
    logic        mode = 1'b0;
    logic        zz = 1'b0;
    logic [35:0] mem_exp [64];
    int          n_mismatch = 0;
    int          checks_done = 0;
    wire  [8:0]  ctl;
    wire  [18:0] ad;
    wire  [35:0] wd;
    wire  [35:0] q;
    wire         q_oe;
    wire         slp;
    always #2 clk = ~clk;
    sbs_host_model i_host (.i_core_clk(clk), .o_ctl(ctl), .o_addr(ad),
        .o_data(wd));
    sbs_ctrl i_dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_addr(ad),
        .i_proc_addr_strobe_n(ctl[8]), .i_ctrl_addr_strobe_n(ctl[7]),
        .i_burst_advance_n(ctl[6]), .i_global_write_n(ctl[5]),
        .i_byte_write_enable_n(ctl[4]), .i_byte_sel_n(ctl[3:0]),
        .i_chip_sel_primary_n(ce1_n), .i_chip_sel_second(1'b1),
        .i_chip_sel_third_n(1'b0), .i_out_enable_n(oe_n),
        .i_burst_order(mode), .i_sleep_req(zz), .i_data(wd), .o_data(q),
        .o_data_oe(q_oe), .o_sleeping(slp), .o_wbuf_full());
    task automatic chk(input logic [35:0] seen, input logic [35:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("ERROR %0t saw %h want %h", $time, seen, want);
        end
    endtask : chk
    task automatic wr(input logic [8:0] k, input logic [5:0] a,
                      input logic [35:0] dv);
        i_host.cyc(k, {13'h0, a}, dv);
        for (int g = 0; g < 4; g++)
            if (k[8] && (!k[5] || (!k[4] && !k[g])))
                mem_exp[a][9*g +: 9] = dv[9*g +: 9];
    endtask : wr
    // output settles within a few cycles; a wait that runs out fails if q is not the expected word
    task automatic rd(input logic [8:0] k, input logic [5:0] a,
                      input logic [35:0] e);
        i_host.cyc(k, {13'h0, a}, 36'h0);
        @(negedge clk);
        // sampled on the falling edge, where outputs have settled
        for (int n = 0; n < 8 && !(q_oe === 1'b1 && q === e); n++)
            @(negedge clk);
        chk(q, e);
        @(posedge clk);
    endtask : rd
    task automatic desel;
        ce1_n <= 1'b1;
        i_host.cyc(9'h0FF, 19'h22, 36'h0);
        i_host.cyc(9'h17F, 19'h23, 36'h0);
        repeat (8) @(posedge clk);
        chk(q, mem_exp[6'h10]);
        ce1_n <= 1'b0;
        rd(9'h0FF, 6'h10, mem_exp[6'h10]);
    endtask : desel
    task automatic burst;
        for (int m = 0; m < 2; m++)
        begin
            // load first: with no step taken the order cannot move data
            rd(9'h0FF, 6'h21, mem_exp[6'h21]);
            mode <= m[0];
            repeat (3) @(posedge clk);
            for (int s = 1; s < 4; s++)
            begin
                int o = m ? (1 ^ s) : (1 + s);
                rd(9'h1BF, 6'h0, mem_exp[6'h20 + 6'(o % 4)]);
            end
        end
    endtask : burst
    task automatic nap;
        zz <= 1'b1;
        for (int n = 0; n < 8 && slp !== 1'b1; n++)
            @(negedge clk);
        chk(36'(slp), 36'h1);
        @(posedge clk);
        zz <= 1'b0;
        for (int n = 0; n < 8 && slp !== 1'b0; n++)
            @(negedge clk);
        @(posedge clk);
        rd(9'h17F, 6'h10, mem_exp[6'h10]);
    endtask : nap
    task automatic wrap_up;
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        wr(9'h15F, 6'h10, 36'hA5A5A5A5A);
        rd(9'h0FF, 6'h10, mem_exp[6'h10]);
        wr(9'h16E, 6'h10, 36'h123456789);
        wr(9'h17E, 6'h10, 36'hFEDCBA987);
        wr(9'h05F, 6'h10, 36'h0);
        rd(9'h17F, 6'h10, mem_exp[6'h10]);
        desel();
        for (int i = 0; i < 4; i++)
            wr(9'h15F, 6'(32 + i), {4{9'(i * 37 + 5)}});
        burst();
        nap();
        oe_n <= 1'b1;
        // two sync flops on the pin: settled by the third falling edge
        repeat (3) @(negedge clk);
        chk(36'(q_oe), 36'h0);
        wrap_up();
    end
endmodule : sbs_ctrl_bench
bind sbs_ctrl sbs_ctrl_chk u_chk (.*);
